// [hw/am_cal_pkg.sv]
// Constants shared by the modulation-depth and antenna-trim calibration.
// Assumes an 8-bit register port and a 100 MHz system clock.
package am_cal_pkg;

  // ==========================================================
  // Register port
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  localparam logic [7:0] OFS_OP_CTRL    = 8'h00;
  localparam logic [7:0] OFS_MOD_CTRL   = 8'h01;
  localparam logic [7:0] OFS_NORM_LVL   = 8'h02;
  localparam logic [7:0] OFS_AM_LVL     = 8'h03;
  localparam logic [7:0] OFS_MOD_RESULT = 8'h04;
  localparam logic [7:0] OFS_ADC_RESULT = 8'h05;
  localparam logic [7:0] OFS_PH_RESULT  = 8'h06;
  localparam logic [7:0] OFS_ANT_CTRL   = 8'h07;
  localparam logic [7:0] OFS_ANT_TARGET = 8'h08;
  localparam logic [7:0] OFS_ANT_RESULT = 8'h09;
  localparam logic [7:0] OFS_STATUS     = 8'h0a;
  localparam logic [7:0] OFS_CMD        = 8'h0b;

  // ==========================================================
  // Field positions
  localparam int OP_TX_EN_BIT   = 0;
  localparam int OP_SINGLE_BIT  = 1;
  localparam int MOD_SRC_BIT    = 7;
  localparam int MOD_CODE_MSB   = 6;
  localparam int MOD_CODE_LSB   = 1;
  localparam int ANT_TRIM_S_BIT = 7;
  localparam int CMD_CAL_MOD    = 0;
  localparam int CMD_MEAS_AMP   = 1;
  localparam int CMD_MEAS_PH    = 2;
  localparam int CMD_CAL_ANT    = 3;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_OP_CTRL  = 8'h00;
  localparam logic [7:0] RST_MOD_CTRL = 8'h00;
  localparam logic [7:0] RST_NORM_LVL = 8'h00;
  localparam logic [7:0] RST_AM_LVL   = 8'h00;
  localparam logic [7:0] RST_ANT_CTRL = 8'h00;
  localparam logic [7:0] RST_ANT_TGT  = 8'h80;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_NS     = 500;
  localparam int SETTLE_CYC    =
    (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 8;

  // ==========================================================
  // Sequencer encodings
  typedef enum logic [2:0] {
    S_IDLE, S_SETTLE, S_MEAS, S_WAIT, S_EVAL
  } seq_state_t;

  typedef enum logic [1:0] {
    J_MOD, J_AMP, J_PHASE, J_ANT
  } job_t;

endpackage : am_cal_pkg

// [hw/sar_search.sv]
// Successive-approximation register, most significant bit first.
// Assumes the caller steps it once per finished trial measurement.
`timescale 1ns/10ps
module sar_search #(
  parameter int WIDTH = 8
) (
  input  wire logic             i_mclk,
  input  wire logic             i_rst_b,
  input  wire logic             i_start,
  input  wire logic             i_step,
  input  wire logic             i_keep,
  output logic [WIDTH-1:0]      o_trial,
  output logic                  o_last,
  output logic [WIDTH-1:0]      o_final
);

  logic [WIDTH-1:0] value_q;
  logic [WIDTH-1:0] mask_q;
  logic [WIDTH-1:0] kept;
  logic [WIDTH-1:0] next_mask;

  // ==========================================================
  // Bit under test is dropped when its trial overshoots
  assign kept      = i_keep ? value_q : (value_q & ~mask_q);
  assign next_mask = mask_q >> 1;
  assign o_trial   = value_q;
  assign o_last    = mask_q[0];
  assign o_final   = kept;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      value_q <= '0;
      mask_q  <= '0;
    end else if (i_start) begin
      value_q <= {1'b1, {(WIDTH-1){1'b0}}};
      mask_q  <= {1'b1, {(WIDTH-1){1'b0}}};
    end else if (i_step && !o_last) begin
      value_q <= kept | next_mask;
      mask_q  <= next_mask;
    end
  end

endmodule : sar_search

// [hw/am_depth_and_antenna_trim_cal.sv]
// Modulation-depth calibration and antenna tuning switch control.
// Assumes an external converter with a start/done handshake that
// measures carrier amplitude or phase at the antenna sense inputs.
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
module am_depth_and_antenna_trim_cal
(
  input  wire logic                        i_mclk,
  input  wire logic                        i_rst_b,
  input  wire logic [am_cal_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [am_cal_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  output logic [am_cal_pkg::DATA_W-1:0]    o_rdata,
  input  wire logic                        i_mod,
  input  wire logic                        i_meas_done,
  input  wire logic [7:0]                  i_meas_data,
  output logic                             o_meas_start,
  output logic                             o_meas_sel,
  output logic                             o_tx_en,
  output logic [7:0]                       o_drv_seg_on,
  output logic [3:0]                       o_tune_bank_a,
  output logic [3:0]                       o_tune_bank_b,
  output logic                             o_busy
);
  import am_cal_pkg::*;

  // ==========================================================
  // Registers
  logic [7:0] op_ctrl_q, mod_ctrl_q, norm_lvl_q, am_lvl_q;
  logic [7:0] mod_res_q, adc_res_q, ph_res_q, ant_ctrl_q;
  logic [7:0] ant_tgt_q, target_q, rdata_q;
  logic [3:0] ant_res_q;
  logic [7:0] seg_q;
  logic [3:0] bank_a_q, bank_b_q;
  logic       tx_en_q, meas_start_q, meas_sel_q, ref_q, busy_q;
  logic [CNT_W-1:0] cnt_q;
  seq_state_t state_q;
  job_t       job_q;

  // ==========================================================
  // Address decode
  wire sel_op    = (i_addr == OFS_OP_CTRL);
  wire sel_modc  = (i_addr == OFS_MOD_CTRL);
  wire sel_norm  = (i_addr == OFS_NORM_LVL);
  wire sel_am    = (i_addr == OFS_AM_LVL);
  wire sel_antc  = (i_addr == OFS_ANT_CTRL);
  wire sel_antt  = (i_addr == OFS_ANT_TARGET);
  wire sel_cmd   = (i_addr == OFS_CMD);
  wire idle      = (state_q == S_IDLE);
  wire cmd_wr    = i_wr && sel_cmd && idle;
  wire go_mod    = cmd_wr && i_wdata[CMD_CAL_MOD];
  wire go_amp    = cmd_wr && !i_wdata[CMD_CAL_MOD] && i_wdata[CMD_MEAS_AMP];
  wire go_ph     = cmd_wr && !i_wdata[CMD_CAL_MOD] &&
                   !i_wdata[CMD_MEAS_AMP] && i_wdata[CMD_MEAS_PH];
  wire go_ant    = cmd_wr && (i_wdata == 8'(1 << CMD_CAL_ANT));
  wire go_any    = go_mod || go_amp || go_ph || go_ant;

  logic [7:0] rd_mux;
  always_comb begin
    case (i_addr)
      OFS_OP_CTRL:    rd_mux = op_ctrl_q;
      OFS_MOD_CTRL:   rd_mux = mod_ctrl_q;
      OFS_NORM_LVL:   rd_mux = norm_lvl_q;
      OFS_AM_LVL:     rd_mux = am_lvl_q;
      OFS_MOD_RESULT: rd_mux = mod_res_q;
      OFS_ADC_RESULT: rd_mux = adc_res_q;
      OFS_PH_RESULT:  rd_mux = ph_res_q;
      OFS_ANT_CTRL:   rd_mux = ant_ctrl_q;
      OFS_ANT_TARGET: rd_mux = ant_tgt_q;
      OFS_ANT_RESULT: rd_mux = {4'h0, ant_res_q};
      OFS_STATUS:     rd_mux = {7'h00, !idle};
      default:        rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      op_ctrl_q  <= RST_OP_CTRL;
      mod_ctrl_q <= RST_MOD_CTRL;
      norm_lvl_q <= RST_NORM_LVL;
      am_lvl_q   <= RST_AM_LVL;
      ant_ctrl_q <= RST_ANT_CTRL;
      ant_tgt_q  <= RST_ANT_TGT;
      rdata_q    <= 8'h00;
    end else begin
      if (i_wr && sel_op)   op_ctrl_q  <= i_wdata;
      if (i_wr && sel_modc) mod_ctrl_q <= i_wdata;
      if (i_wr && sel_norm) norm_lvl_q <= i_wdata;
      if (i_wr && sel_am)   am_lvl_q   <= i_wdata;
      if (i_wr && sel_antc) ant_ctrl_q <= i_wdata;
      if (i_wr && sel_antt) ant_tgt_q  <= i_wdata;
      // Data stand only in the cycle after the strobe
      rdata_q <= i_rd ? rd_mux : 8'h00;
    end
  end

  // ==========================================================
  // Target level: measurement / (1 + code/64)
  wire        src_sw   = mod_ctrl_q[MOD_SRC_BIT];
  wire [5:0]  code     = mod_ctrl_q[MOD_CODE_MSB:MOD_CODE_LSB];
  wire [13:0] tgt_num  = {adc_res_q, 6'h00};
  wire [6:0]  tgt_den  = {1'b1, code};
  wire [13:0] tgt_quot = tgt_num / {7'h00, tgt_den};
  wire [7:0]  tgt_calc = tgt_quot[7:0];

  // ==========================================================
  // Searches: driver strength and trim switches
  logic [7:0] sar_m_trial, sar_m_final;
  logic [3:0] sar_t_trial, sar_t_final;
  logic       sar_m_last, sar_t_last;
  wire eval_mod = (state_q == S_EVAL) && (job_q == J_MOD);
  wire eval_ant = (state_q == S_EVAL) && (job_q == J_ANT);
  wire mod_start = eval_mod && !ref_q;
  wire mod_step  = eval_mod && ref_q;
  // Stronger segment-off keeps amplitude at or above target
  wire mod_keep  = (adc_res_q >= target_q);
  wire ant_keep  = (ph_res_q <= ant_tgt_q);

  sar_search #(.WIDTH(8)) u_sar_mod (
    .i_mclk  (i_mclk),
    .i_rst_b (i_rst_b),
    .i_start (mod_start),
    .i_step  (mod_step),
    .i_keep  (mod_keep),
    .o_trial (sar_m_trial),
    .o_last  (sar_m_last),
    .o_final (sar_m_final)
  );

  sar_search #(.WIDTH(4)) u_sar_ant (
    .i_mclk  (i_mclk),
    .i_rst_b (i_rst_b),
    .i_start (go_ant),
    .i_step  (eval_ant),
    .i_keep  (ant_keep),
    .o_trial (sar_t_trial),
    .o_last  (sar_t_last),
    .o_final (sar_t_final)
  );

  // ==========================================================
  // Sequencer
  wire capture   = (state_q == S_WAIT) && i_meas_done;
  wire is_amp    = (job_q == J_MOD) || (job_q == J_AMP);
  wire mod_done  = mod_step && sar_m_last;
  wire ant_done  = eval_ant && sar_t_last;
  wire seq_end   = (state_q == S_EVAL) && ((job_q == J_AMP) ||
                   (job_q == J_PHASE) || mod_done || ant_done);

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q      <= S_IDLE;
      job_q        <= J_AMP;
      ref_q        <= 1'b0;
      cnt_q        <= '0;
      meas_start_q <= 1'b0;
      meas_sel_q   <= 1'b0;
      target_q     <= 8'h00;
      busy_q       <= 1'b0;
    end else begin
      meas_start_q <= 1'b0;
      busy_q       <= idle ? go_any : !seq_end;
      case (state_q)
        S_IDLE: begin
          if (go_any) begin
            state_q <= S_SETTLE;
            cnt_q   <= CNT_W'(SETTLE_CYC);
            ref_q   <= 1'b0;
            job_q   <= go_mod ? J_MOD : go_amp ? J_AMP :
                       go_ph ? J_PHASE : J_ANT;
          end
        end
        S_SETTLE: begin
          if (cnt_q == '0) begin
            state_q <= S_MEAS;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        S_MEAS: begin
          meas_start_q <= 1'b1;
          meas_sel_q   <= !is_amp;
          state_q      <= S_WAIT;
        end
        S_WAIT: begin
          if (i_meas_done) begin
            state_q <= S_EVAL;
          end
        end
        S_EVAL: begin
          if (mod_start) begin
            target_q <= tgt_calc;
            ref_q    <= 1'b1;
          end
          if (seq_end) begin
            state_q <= S_IDLE;
          end else begin
            state_q <= S_SETTLE;
            cnt_q   <= CNT_W'(SETTLE_CYC);
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Results
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      adc_res_q <= 8'h00;
      ph_res_q  <= 8'h00;
      mod_res_q <= 8'h00;
      ant_res_q <= 4'h0;
    end else begin
      if (capture && is_amp)  adc_res_q <= i_meas_data;
      if (capture && !is_amp) ph_res_q  <= i_meas_data;
      if (mod_done)           mod_res_q <= sar_m_final;
      if (ant_done)           ant_res_q <= sar_t_final;
    end
  end

  // ==========================================================
  // Driver level: a set level bit switches that segment off
  wire cal_mod   = !idle && (job_q == J_MOD);
  wire cal_trial = cal_mod && ref_q && !(state_q == S_EVAL);
  wire [7:0] mod_lvl = src_sw ? am_lvl_q : mod_res_q;
  wire [7:0] level   = cal_trial ? sar_m_trial :
                       (idle && i_mod) ? mod_lvl : norm_lvl_q;
  wire [3:0] trim    = (!idle && job_q == J_ANT) ? sar_t_trial :
                       ant_ctrl_q[ANT_TRIM_S_BIT] ? ant_ctrl_q[3:0] :
                       ant_res_q;
  wire single = op_ctrl_q[OP_SINGLE_BIT];

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      seg_q    <= 8'hff;
      tx_en_q  <= 1'b0;
      bank_a_q <= 4'h0;
      bank_b_q <= 4'h0;
    end else begin
      seg_q    <= ~level;
      // Depth calibration owns the transmitter while it runs
      tx_en_q  <= op_ctrl_q[OP_TX_EN_BIT] || cal_mod || go_mod;
      bank_a_q <= trim;
      bank_b_q <= single ? 4'h0 : trim;
    end
  end

  assign o_rdata       = rdata_q;
  assign o_meas_start  = meas_start_q;
  assign o_meas_sel    = meas_sel_q;
  assign o_tx_en       = tx_en_q;
  assign o_drv_seg_on  = seg_q;
  assign o_tune_bank_a = bank_a_q;
  assign o_tune_bank_b = bank_b_q;
  assign o_busy        = busy_q;

  // ==========================================================
  // Checks
  property p_norm_level;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (idle && !i_mod) |=> (o_drv_seg_on == ~$past(norm_lvl_q));
  endproperty
  a_norm_level: assert property (p_norm_level)
    else $error("normal level not applied");

  property p_sw_level;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (idle && i_mod && src_sw) |=> (o_drv_seg_on == ~$past(am_lvl_q));
  endproperty
  a_sw_level: assert property (p_sw_level)
    else $error("software modulated level not applied");

  property p_cal_level;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (idle && i_mod && !src_sw) |=> (o_drv_seg_on == ~$past(mod_res_q));
  endproperty
  a_cal_level: assert property (p_cal_level)
    else $error("calibrated level not applied");

  property p_cal_start;
    @(posedge i_mclk) disable iff (!i_rst_b)
    go_mod |=> (o_tx_en && state_q == S_SETTLE) [*2];
  endproperty
  a_cal_start: assert property (p_cal_start)
    else $error("calibration did not enable transmitter");

  property p_ref_store;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (capture && job_q == J_MOD) |=> (adc_res_q == $past(i_meas_data));
  endproperty
  a_ref_store: assert property (p_ref_store)
    else $error("reference amplitude not stored");

  property p_first_trial;
    @(posedge i_mclk) disable iff (!i_rst_b)
    mod_start |=> ##1 (o_drv_seg_on[7] == 1'b0);
  endproperty
  a_first_trial: assert property (p_first_trial)
    else $error("search did not start at top segment");
  property p_target;
    @(posedge i_mclk) disable iff (!i_rst_b)
    mod_start |=> (target_q * ({1'b1, $past(code)}) <=
                   {$past(adc_res_q), 6'h00}) &&
                  ((target_q + 15'd1) * {1'b1, $past(code)} >
                   {$past(adc_res_q), 6'h00});
  endproperty
  a_target: assert property (p_target)
    else $error("target level is not the truncated ratio");
  property p_bank_pair;
    @(posedge i_mclk) disable iff (!i_rst_b)
    !$past(single) |-> (o_tune_bank_b == o_tune_bank_a);
  endproperty
  a_bank_pair: assert property (p_bank_pair)
    else $error("tuning banks disagree");
  property p_bank_single;
    @(posedge i_mclk) disable iff (!i_rst_b)
    $past(single) |-> (o_tune_bank_b == 4'h0);
  endproperty
  a_bank_single: assert property (p_bank_single)
    else $error("second bank driven in single mode");
  property p_host_trim;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (idle && ant_ctrl_q[ANT_TRIM_S_BIT])
      |=> (o_tune_bank_a == $past(ant_ctrl_q[3:0]));
  endproperty
  a_host_trim: assert property (p_host_trim)
    else $error("host trim setting not applied");

  property p_phase_sel;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (o_meas_start && job_q == J_PHASE) |-> o_meas_sel;
  endproperty
  a_phase_sel: assert property (p_phase_sel)
    else $error("phase job started amplitude measurement");

  c_mod_done: cover property (@(posedge i_mclk) mod_done);
  c_ant_done: cover property (@(posedge i_mclk) ant_done);
  c_amp_meas: cover property (@(posedge i_mclk)
    capture && job_q == J_AMP);
  c_sw_mod:   cover property (@(posedge i_mclk) idle && i_mod && src_sw);

endmodule : am_depth_and_antenna_trim_cal

// [verification/conv_model.sv]
// Converter and antenna model seen from the sense inputs.
// Assumes one measurement outstanding and a one-cycle start pulse.
`timescale 1ns/10ps
module conv_model (
  input  wire logic       i_mclk,
  input  wire logic       i_rst_b,
  input  wire logic       i_start,
  input  wire logic       i_sel,
  input  wire logic [7:0] i_seg_on,
  input  wire logic [3:0] i_trim,
  output logic            o_done,
  output logic [7:0]      o_data
);
  // ==========================================================
  // Answer after 1 to 5 cycles, so prompt and slow answers occur
  int   wait_q;
  int   lat_q;
  logic sel_q;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wait_q <= 0;
      lat_q  <= 1;
      sel_q  <= 1'b0;
      o_done <= 1'b0;
      o_data <= 8'h5a;
    end else begin
      o_done <= 1'b0;
      // Data is meaningless outside done, so it never holds still
      o_data <= ~o_data;
      if (i_start) begin
        wait_q <= lat_q;
        sel_q  <= i_sel;
        lat_q  <= (lat_q % 5) + 1;
      end else if (wait_q > 1) begin
        wait_q <= wait_q - 1;
      end else if (wait_q == 1) begin
        wait_q <= 0;
        o_done <= 1'b1;
        // Fewer segments on, weaker field; more trim, more phase
        o_data <= sel_q ? {i_trim, 4'h0} : i_seg_on;
      end
    end
  end
endmodule : conv_model

// [verification/testbench.sv]
// Self-checking bench for modulation-depth and trim calibration.
// Assumes conv_model answers every measurement start.
`timescale 1ns/10ps
module testbench;
  import am_cal_pkg::*;
  logic       i_mclk;
  logic       i_rst_b;
  logic [7:0] i_addr;
  logic [7:0] i_wdata;
  logic       i_wr;
  logic       i_rd;
  logic       i_mod;
  logic [7:0] o_rdata;
  logic       i_meas_done;
  logic [7:0] i_meas_data;
  logic       o_meas_start;
  logic       o_meas_sel;
  logic       o_tx_en;
  logic [7:0] o_drv_seg_on;
  logic [3:0] o_tune_bank_a;
  logic [3:0] o_tune_bank_b;
  logic       o_busy;
  int         failures;
  int         num_checks;
  logic [7:0] rd_v;
  logic [7:0] lvl_v;
  logic [7:0] tgt_v;
  logic [5:0] code_v;

  am_depth_and_antenna_trim_cal am_depth_and_antenna_trim_cal_i (
    .i_mclk, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_mod, .i_meas_done, .i_meas_data, .o_meas_start, .o_meas_sel,
    .o_tx_en, .o_drv_seg_on, .o_tune_bank_a, .o_tune_bank_b, .o_busy);

  conv_model conv_model_i (
    .i_mclk, .i_rst_b, .i_start(o_meas_start), .i_sel(o_meas_sel),
    .i_seg_on(o_drv_seg_on), .i_trim(o_tune_bank_a),
    .o_done(i_meas_done), .o_data(i_meas_data));

  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  // ==========================================================
  // Bus and check tasks
  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_mclk);
    i_wr    <= 1'b0;
  endtask : wr

  task automatic rchk(input string what, input logic [7:0] a,
                      input logic [7:0] exp);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_mclk);
    i_rd   <= 1'b0;
    #1 rd_v = o_rdata;
    chk(what, rd_v, exp);
  endtask : rchk

  task automatic settle();
    repeat (3) @(posedge i_mclk);
    #1;
  endtask : settle

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  // Bounded wait; a hang counts as a mismatch and ends the run
  task automatic run_cmd(input logic [7:0] c, input logic tx_chk);
    int n;
    wr(OFS_CMD, c);
    #1 n = 0;
    if (tx_chk) chk("tx_en", {7'h0, o_tx_en}, 8'h01);
    rchk("busy_rd", OFS_STATUS, 8'h01);
    while (o_busy !== 1'b0 && n < 5000) begin
      @(posedge i_mclk);
      #1 n++;
    end
    if (o_busy !== 1'b0) begin
      chk("busy", {7'h0, o_busy}, 8'h00);
      final_report();
    end
  endtask : run_cmd

  // Truncated target, then the largest level still at or above it
  function automatic logic [7:0] exp_mod(input logic [7:0] r,
                                         input logic [5:0] c);
    int t;
    t = (int'(r) * 64) / (64 + int'(c));
    return 8'(255 - t);
  endfunction : exp_mod

  // ==========================================================
  // Main sequence
  initial begin
    i_rst_b = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_mod = 1'b0;
    failures = 0;
    num_checks = 0;
    void'($urandom(3321));
    repeat (4) @(posedge i_mclk);
    chk("seg_rst", o_drv_seg_on, 8'hff);
    i_rst_b <= 1'b1;
    rchk("op_ctrl", OFS_OP_CTRL, RST_OP_CTRL);
    rchk("mod_ctrl", OFS_MOD_CTRL, RST_MOD_CTRL);
    rchk("norm_lvl", OFS_NORM_LVL, RST_NORM_LVL);
    rchk("am_lvl", OFS_AM_LVL, RST_AM_LVL);
    rchk("ant_ctrl", OFS_ANT_CTRL, RST_ANT_CTRL);
    rchk("ant_tgt", OFS_ANT_TARGET, RST_ANT_TGT);
    rchk("unmapped", 8'h3c, 8'h00);
    $display("test reset done");

    // Antenna first, as depth calibration depends on the tuning
    for (int k = 0; k < 4; k++) begin
      tgt_v = (k == 0) ? 8'h80 : (k == 1) ? 8'h00 :
              (k == 2) ? 8'hff : 8'($urandom);
      wr(OFS_ANT_TARGET, tgt_v);
      run_cmd(8'h08, 1'b0);
      rchk("ant_res", OFS_ANT_RESULT, {4'h0, tgt_v[7:4]});
      chk("bank_a", {4'h0, o_tune_bank_a}, {4'h0, tgt_v[7:4]});
      chk("bank_b", {4'h0, o_tune_bank_b}, {4'h0, tgt_v[7:4]});
    end
    tgt_v = 8'($urandom);
    wr(OFS_ANT_CTRL, {4'h8, tgt_v[3:0]});
    settle();
    chk("host_trim", {4'h0, o_tune_bank_b}, {4'h0, tgt_v[3:0]});
    wr(OFS_OP_CTRL, 8'h02);
    settle();
    chk("single_a", {4'h0, o_tune_bank_a}, {4'h0, tgt_v[3:0]});
    chk("single_b", {4'h0, o_tune_bank_b}, 8'h00);
    wr(OFS_OP_CTRL, 8'h00);
    run_cmd(8'h04, 1'b0);
    rchk("phase", OFS_PH_RESULT, {tgt_v[3:0], 4'h0});
    wr(OFS_ANT_CTRL, 8'h00);
    $display("test antenna done");

    for (int k = 0; k < 5; k++) begin
      code_v = (k == 0) ? 6'h00 : (k == 1) ? 6'h0e :
               (k == 2) ? 6'h3f : 6'($urandom);
      lvl_v = (k < 3) ? 8'h00 : 8'($urandom);
      wr(OFS_NORM_LVL, lvl_v);
      wr(OFS_MOD_CTRL, {1'b0, code_v, 1'b0});
      run_cmd(8'h01, 1'b1);
      // The last trial overwrites the reference measurement
      tgt_v = exp_mod(~lvl_v, code_v) | 8'h01;
      rchk("adc_last", OFS_ADC_RESULT, ~tgt_v);
      rchk("mod_res", OFS_MOD_RESULT, exp_mod(~lvl_v, code_v));
      @(posedge i_mclk);
      i_mod <= 1'b1;
      settle();
      chk("seg_mod", o_drv_seg_on, ~exp_mod(~lvl_v, code_v));
      @(posedge i_mclk);
      i_mod <= 1'b0;
      settle();
      chk("seg_norm", o_drv_seg_on, ~lvl_v);
    end
    wr(OFS_MOD_RESULT, 8'h3c);
    rchk("mod_ro", OFS_MOD_RESULT, exp_mod(~lvl_v, code_v));
    $display("test depth done");

    // Half depth is past the automatic range; the host searches
    wr(OFS_NORM_LVL, 8'h00);
    wr(OFS_OP_CTRL, 8'h01);
    run_cmd(8'h02, 1'b0);
    rchk("adc_meas", OFS_ADC_RESULT, 8'hff);
    tgt_v = rd_v / 3;
    lvl_v = 8'h00;
    for (int b = 7; b >= 0; b--) begin
      lvl_v[b] = 1'b1;
      wr(OFS_NORM_LVL, lvl_v);
      run_cmd(8'h02, 1'b0);
      rchk("adc_trial", OFS_ADC_RESULT, ~lvl_v);
      if (rd_v < tgt_v) lvl_v[b] = 1'b0;
    end
    chk("host_best", lvl_v, 8'd255 - tgt_v);
    wr(OFS_AM_LVL, lvl_v);
    wr(OFS_NORM_LVL, 8'h00);
    wr(OFS_MOD_CTRL, 8'h80);
    rchk("am_lvl_rb", OFS_AM_LVL, lvl_v);
    @(posedge i_mclk);
    i_mod <= 1'b1;
    settle();
    chk("seg_sw", o_drv_seg_on, ~lvl_v);
    @(posedge i_mclk);
    i_mod <= 1'b0;
    settle();
    chk("seg_idle", o_drv_seg_on, 8'hff);
    $display("test host calibration done");
    final_report();
  end
endmodule : testbench
